// file: core/ebps_top.v
// external bus phase sequencer: runs one parallel bus cycle per start
// assumes a register port master on ref_clk and an external memory on pins
// Function
// - cycle runs setup, command delay, write setup, access, hold in order
// - phase lengths come from software timing configuration registers
// - setup lasts 1 or 2 ticks, plus 0 to 3 when window changes
// - command delay 0-3, access 1-32, hold 0-3 ticks
// - write setup phase is 0 or 1 tick; mux bus turnaround falls in the command delay phase
// - with ready enabled, access phase holds until ready allows end
// - read data captured on edge that releases read strobe
// - address moves before read strobe end do not disturb captured data
// - reference clock output follows system clock period when enabled
// - multiplexed 16-line mode and demultiplexed 24-bit address, 16-bit data
// - ready polarity selectable
// - ready synchronous or via extra synchroniser stage
// - inactive ready adds wait state, active ready ends access phase
`timescale 1ns/1ps
`include "ebps_consts.vh"
module ebps_top #(
   parameter AW = 24,
   parameter DW = 16
) (
   input  wire          ref_clk,
   input  wire          reset,
   input  wire [3:0]    reg_addr,
   input  wire [15:0]   reg_wdata,
   input  wire          reg_wr,
   input  wire          reg_rd,
   output reg  [15:0]   reg_rdata,
   output wire          bus_reference_clock_out,
   output wire          external_clock_pin_output,
   output reg           chip_select_n,
   output reg           addr_latch,
   output reg           read_n,
   output reg           write_lo_n,
   output reg           write_hi_n,
   output reg           upper_byte_enable_n,
   output reg  [AW-1:0] demux_address_bus,
   input  wire [DW-1:0] demux_data_bus_in,
   output reg  [DW-1:0] demux_data_bus_out,
   output reg           demux_data_bus_oe,
   input  wire [DW-1:0] muxed_addr_data_bus_in,
   output reg  [DW-1:0] muxed_addr_data_bus_out,
   output reg           muxed_addr_data_bus_oe,
   input  wire          ready_in
);
   localparam S_IDLE   = 3'd0;
   localparam S_SETUP  = 3'd1;
   localparam S_CMD    = 3'd2;
   localparam S_WSETUP = 3'd3;
   localparam S_ACCESS = 3'd4;
   localparam S_WAIT   = 3'd5;
   localparam S_HOLD   = 3'd6;

   reg [15:0]   ctrl_q;
   reg [15:0]   tim0_q;
   reg [15:0]   tim1_q;
   reg [AW-1:0] addr_q;
   reg [DW-1:0] wdata_q;
   reg [DW-1:0] rdata_q;
   reg          go_q;
   reg          done_q;
   reg [2:0]    state_q;
   reg [5:0]    cnt_q;
   reg [AW-1:0] last_win_q;
   reg          win_valid_q;
   reg          rdy_extra_q;
   reg          cap_q;

   wire         busy = (state_q != S_IDLE);
   wire         is_wr = ctrl_q[`EBPS_CTRL_WRITE];
   wire         mux = ctrl_q[`EBPS_CTRL_MUX];
   wire         rdy_en = ctrl_q[`EBPS_CTRL_RDY_EN];
   wire [1:0]   extra = tim0_q[`EBPS_T0_EXTRA +: 2];
   wire [1:0]   cmd_len = tim0_q[`EBPS_T0_CMD +: 2];
   wire         ws_len = tim0_q[`EBPS_T0_WSETUP];
   wire [1:0]   hold_len = tim0_q[`EBPS_T0_HOLD +: 2];
   wire [4:0]   acc_m1 = tim1_q[`EBPS_T1_ACCESS +: 5];

   ////////////////////////////////////////////////////////////////////////
   // ready input: two-flop sync, optional extra stage, polarity
   wire rdy_sync;
   ebps_sync u_rdy_sync (
      .ref_clk (ref_clk),
      .reset   (reset),
      .din     (ready_in),
      .dout    (rdy_sync)
   );

   always @(posedge ref_clk or posedge reset) begin
      if (reset)
         rdy_extra_q <= 1'b0;
      else
         rdy_extra_q <= rdy_sync;
   end

   wire rdy_raw = ctrl_q[`EBPS_CTRL_RDY_ASY] ? rdy_extra_q : rdy_sync;
   wire rdy_act = rdy_raw ^ ctrl_q[`EBPS_CTRL_RDY_POL];

   ////////////////////////////////////////////////////////////////////////
   // reference clock output
   assign bus_reference_clock_out  = ctrl_q[`EBPS_CTRL_CLK_EN] & ref_clk;
   assign external_clock_pin_output = bus_reference_clock_out;

   ////////////////////////////////////////////////////////////////////////
   // register port
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         ctrl_q  <= `EBPS_CTRL_RESET;
         tim0_q  <= `EBPS_T0_RESET;
         tim1_q  <= `EBPS_T1_RESET;
         addr_q  <= {AW{1'b0}};
         wdata_q <= {DW{1'b0}};
         go_q    <= 1'b0;
      end else begin
         go_q <= 1'b0;
         if (reg_wr && !busy) begin
            case (reg_addr)
               `EBPS_REG_CTRL: begin
                  ctrl_q <= reg_wdata;
                  go_q   <= reg_wdata[`EBPS_CTRL_GO];
               end
               `EBPS_REG_TIMING0: tim0_q <= reg_wdata;
               `EBPS_REG_TIMING1: tim1_q <= reg_wdata;
               `EBPS_REG_ADDR_LO: addr_q[15:0] <= reg_wdata;
               `EBPS_REG_ADDR_HI: addr_q[AW-1:16] <= reg_wdata[AW-17:0];
               `EBPS_REG_WDATA:   wdata_q <= reg_wdata;
               default: ;
            endcase
         end
      end
   end

   always @(posedge ref_clk or posedge reset) begin
      if (reset)
         reg_rdata <= 16'h0000;
      else if (reg_rd) begin
         case (reg_addr)
            `EBPS_REG_CTRL:    reg_rdata <= ctrl_q;
            `EBPS_REG_TIMING0: reg_rdata <= tim0_q;
            `EBPS_REG_TIMING1: reg_rdata <= tim1_q;
            `EBPS_REG_ADDR_LO: reg_rdata <= addr_q[15:0];
            `EBPS_REG_ADDR_HI: reg_rdata <= {8'h00, addr_q[AW-1:16]};
            `EBPS_REG_WDATA:   reg_rdata <= wdata_q;
            `EBPS_REG_RDATA:   reg_rdata <= rdata_q;
            `EBPS_REG_STATUS:  reg_rdata <= {13'h0000, state_q == S_WAIT, done_q, busy};
            default:           reg_rdata <= 16'h0000;
         endcase
      end else
         reg_rdata <= 16'h0000;
   end

   ////////////////////////////////////////////////////////////////////////
   // phase sequencer; one tick = one ref_clk cycle
   wire       win_change = !win_valid_q || (last_win_q[AW-1:16] != addr_q[AW-1:16]);
   wire [5:0] setup_len = {5'd0, tim0_q[`EBPS_T0_SETUP]} + 6'd1 +
                          (win_change ? {4'd0, extra} : 6'd0);
   wire       last = (cnt_q == 6'd1);

   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         state_q     <= S_IDLE;
         cnt_q       <= 6'd0;
         done_q      <= 1'b0;
         rdata_q     <= {DW{1'b0}};
         last_win_q  <= {AW{1'b0}};
         win_valid_q <= 1'b0;
         cap_q       <= 1'b0;
      end else begin
         // read strobe lags the phase by one edge: latch on its release
         cap_q <= 1'b0;
         if (cap_q)
            rdata_q <= mux ? muxed_addr_data_bus_in : demux_data_bus_in;
         if (reg_rd && reg_addr == `EBPS_REG_STATUS && !(busy && state_q == S_HOLD && last))
            done_q <= 1'b0;
         case (state_q)
            S_IDLE: begin
               if (go_q) begin
                  state_q <= S_SETUP;
                  cnt_q   <= setup_len;
                  done_q  <= 1'b0;
               end
            end
            S_SETUP: begin
               if (last) begin
                  last_win_q  <= addr_q;
                  win_valid_q <= 1'b1;
                  if (cmd_len != 2'd0) begin
                     state_q <= S_CMD;
                     cnt_q   <= {4'd0, cmd_len};
                  end else if (ws_len) begin
                     state_q <= S_WSETUP;
                     cnt_q   <= 6'd1;
                  end else begin
                     state_q <= S_ACCESS;
                     cnt_q   <= {1'b0, acc_m1} + 6'd1;
                  end
               end else
                  cnt_q <= cnt_q - 6'd1;
            end
            S_CMD: begin
               if (last) begin
                  if (ws_len) begin
                     state_q <= S_WSETUP;
                     cnt_q   <= 6'd1;
                  end else begin
                     state_q <= S_ACCESS;
                     cnt_q   <= {1'b0, acc_m1} + 6'd1;
                  end
               end else
                  cnt_q <= cnt_q - 6'd1;
            end
            S_WSETUP: begin
               state_q <= S_ACCESS;
               cnt_q   <= {1'b0, acc_m1} + 6'd1;
            end
            S_ACCESS, S_WAIT: begin
               if (last && (!rdy_en || rdy_act)) begin
                  cap_q <= !is_wr;
                  if (hold_len != 2'd0) begin
                     state_q <= S_HOLD;
                     cnt_q   <= {4'd0, hold_len};
                  end else begin
                     state_q <= S_IDLE;
                     done_q  <= 1'b1;
                  end
               end else if (last)
                  state_q <= S_WAIT;
               else
                  cnt_q <= cnt_q - 6'd1;
            end
            S_HOLD: begin
               if (last) begin
                  state_q <= S_IDLE;
                  done_q  <= 1'b1;
               end else
                  cnt_q <= cnt_q - 6'd1;
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin drivers, registered from state so strobes move one edge after phase edges
   reg [2:0] nxt_phase;
   always @* begin
      nxt_phase = state_q;
   end

   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         chip_select_n           <= 1'b1;
         addr_latch              <= 1'b0;
         read_n                  <= 1'b1;
         write_lo_n              <= 1'b1;
         write_hi_n              <= 1'b1;
         upper_byte_enable_n     <= 1'b1;
         demux_address_bus       <= {AW{1'b0}};
         demux_data_bus_out      <= {DW{1'b0}};
         demux_data_bus_oe       <= 1'b0;
         muxed_addr_data_bus_out <= {DW{1'b0}};
         muxed_addr_data_bus_oe  <= 1'b0;
      end else begin
         // outputs follow the phase register one edge later
         chip_select_n       <= !(busy && nxt_phase != S_IDLE);
         addr_latch          <= mux && nxt_phase == S_SETUP;
         read_n              <= !(!is_wr && (nxt_phase == S_ACCESS || nxt_phase == S_WAIT));
         write_lo_n          <= !(is_wr && ctrl_q[`EBPS_CTRL_BYTE_LO] &&
                                  (nxt_phase == S_ACCESS || nxt_phase == S_WAIT));
         write_hi_n          <= !(is_wr && ctrl_q[`EBPS_CTRL_BYTE_HI] &&
                                  (nxt_phase == S_ACCESS || nxt_phase == S_WAIT));
         upper_byte_enable_n <= !(busy && ctrl_q[`EBPS_CTRL_BYTE_HI]);
         if (busy)
            demux_address_bus <= addr_q;
         demux_data_bus_out  <= wdata_q;
         demux_data_bus_oe   <= !mux && is_wr && busy && nxt_phase != S_SETUP;
         if (nxt_phase == S_SETUP) begin
            muxed_addr_data_bus_out <= addr_q[DW-1:0];
            muxed_addr_data_bus_oe  <= mux;
         end else begin
            muxed_addr_data_bus_out <= wdata_q;
            // turnaround: bus released in command phase, write data after
            muxed_addr_data_bus_oe  <= mux && is_wr && busy && nxt_phase != S_CMD;
         end
      end
   end
endmodule

// file: core/ebps_consts.vh
// constants of the external bus phase sequencer
// assumes inclusion by bare name from core/ design files
`ifndef EBPS_CONSTS_VH
`define EBPS_CONSTS_VH

// register indices of the command port
`define EBPS_REG_CTRL      4'h0
`define EBPS_REG_TIMING0   4'h1
`define EBPS_REG_TIMING1   4'h2
`define EBPS_REG_ADDR_LO   4'h3
`define EBPS_REG_ADDR_HI   4'h4
`define EBPS_REG_WDATA     4'h5
`define EBPS_REG_RDATA     4'h6
`define EBPS_REG_STATUS    4'h7

// ctrl fields
`define EBPS_CTRL_GO       0
`define EBPS_CTRL_WRITE    1
`define EBPS_CTRL_MUX      2
`define EBPS_CTRL_RDY_EN   3
`define EBPS_CTRL_RDY_POL  4
`define EBPS_CTRL_RDY_ASY  5
`define EBPS_CTRL_BYTE_LO  6
`define EBPS_CTRL_BYTE_HI  7
`define EBPS_CTRL_CLK_EN   8

// timing0 fields: setup[0], extra[2:1], cmd[4:3], wsetup[5], hold[7:6]
`define EBPS_T0_SETUP      0
`define EBPS_T0_EXTRA      1
`define EBPS_T0_CMD        3
`define EBPS_T0_WSETUP     5
`define EBPS_T0_HOLD       6
// timing1: access length minus one, 5 bits
`define EBPS_T1_ACCESS     0

`define EBPS_CTRL_RESET    16'h0000
`define EBPS_T0_RESET      16'h0000
`define EBPS_T1_RESET      16'h0000

`endif

// file: core/ebps_sync.v
// two flip-flop synchroniser for one level
// assumes input from outside the ref_clk domain
`timescale 1ns/1ps
module ebps_sync (
   input  wire ref_clk,
   input  wire reset,
   input  wire din,
   output wire dout
);
   reg meta_q;
   reg sync_q;

   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= din;
         sync_q <= meta_q;
      end
   end

   assign dout = sync_q;
endmodule

// file: verification/ebps_checker.sv
// pin and register-port assertions for the phase sequencer
// assumes binding into ebps_top; one ref_clk domain, async high reset
`timescale 1ns/1ps
module ebps_checker #(
   parameter AW = 24,
   parameter DW = 16
) (
   input wire          ref_clk,
   input wire          reset,
   input wire          reg_rd,
   input wire [15:0]   reg_rdata,
   input wire          bus_reference_clock_out,
   input wire          external_clock_pin_output,
   input wire          chip_select_n,
   input wire          addr_latch,
   input wire          read_n,
   input wire          write_lo_n,
   input wire          write_hi_n,
   input wire          upper_byte_enable_n,
   input wire [AW-1:0] demux_address_bus,
   input wire [DW-1:0] demux_data_bus_out,
   input wire          demux_data_bus_oe,
   input wire          muxed_addr_data_bus_oe
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   wire strb_off = read_n && write_lo_n && write_hi_n;
   AST_STROBE_EXCL: assert property (!read_n |-> write_lo_n && write_hi_n)
      else $error("read and write strobes together");
   AST_IDLE_QUIET: assert property (chip_select_n |-> strb_off)
      else $error("strobe outside chip select");
   AST_SETUP_FIRST: assert property ($fell(chip_select_n) |-> strb_off)
      else $error("strobe in first setup tick");
   AST_CYCLE_BOUND: assert property ($fell(chip_select_n) |-> ##1 !chip_select_n ##[1:200] chip_select_n)
      else $error("bus cycle length out of range");
   AST_READ_BOUND: assert property ($fell(read_n) |-> ##[1:200] read_n)
      else $error("read strobe never released");
   AST_ADDR_HELD: assert property (!read_n && !$past(read_n) |-> $stable(demux_address_bus))
      else $error("address moved under read strobe");
   AST_WDATA_HELD: assert property (!write_lo_n && !$past(write_lo_n) && demux_data_bus_oe
      |-> $stable(demux_data_bus_out))
      else $error("write data moved under strobe");
   AST_NO_DRIVE_READ: assert property (!read_n |-> !demux_data_bus_oe && !muxed_addr_data_bus_oe)
      else $error("bus driven during read");
   AST_LATCH_SETUP: assert property (addr_latch |-> strb_off && !chip_select_n)
      else $error("address latch outside setup");
   AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data without read strobe");
   AST_CLK_SAME: assert property (@(negedge ref_clk) disable iff (reset)
      bus_reference_clock_out == external_clock_pin_output)
      else $error("clock outputs differ");
   AST_CLK_LOW: assert property (!bus_reference_clock_out)
      else $error("reference clock high in low half");
   AST_UBE_IN_CYCLE: assert property (chip_select_n |-> upper_byte_enable_n)
      else $error("byte enable outside chip select");
   AST_UBE_HI_WRITE: assert property (!write_hi_n |-> !upper_byte_enable_n)
      else $error("high write without byte enable");
   COV_READ: cover property ($fell(read_n));
   COV_WRITE: cover property ($fell(write_hi_n));
   COV_MUX: cover property ($rose(addr_latch));
endmodule
bind ebps_top ebps_checker #(.AW(AW), .DW(DW)) i_ebps_checker (
   .ref_clk(ref_clk), .reset(reset), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .bus_reference_clock_out(bus_reference_clock_out), .external_clock_pin_output(external_clock_pin_output),
   .chip_select_n(chip_select_n), .addr_latch(addr_latch), .read_n(read_n), .write_lo_n(write_lo_n),
   .write_hi_n(write_hi_n), .upper_byte_enable_n(upper_byte_enable_n),
   .demux_address_bus(demux_address_bus), .demux_data_bus_out(demux_data_bus_out),
   .demux_data_bus_oe(demux_data_bus_oe), .muxed_addr_data_bus_oe(muxed_addr_data_bus_oe)
);

// file: verification/ebps_mem_model.sv
// external 16-word memory on the sequencer pins
// assumes ref_clk shared with the sequencer; ready timed by lk_clk
`timescale 1ns/1ps
module ebps_mem_model (
   input  wire        ref_clk,
   input  wire        lk_clk,
   input  wire        rdy_pol,
   input  wire [2:0]  rdy_dly,
   input  wire        chip_select_n,
   input  wire        addr_latch,
   input  wire        read_n,
   input  wire        write_lo_n,
   input  wire        write_hi_n,
   input  wire [23:0] demux_address_bus,
   input  wire [15:0] demux_data_bus_out,
   input  wire        demux_data_bus_oe,
   input  wire [15:0] muxed_addr_data_bus_out,
   input  wire        muxed_addr_data_bus_oe,
   output wire [15:0] demux_data_bus_in,
   output wire [15:0] muxed_addr_data_bus_in,
   output wire        ready_in
);
   reg  [15:0] mem [0:15];
   reg  [15:0] last_q = 16'h0000;
   reg  [3:0]  mx_a_q = 4'h0;
   reg         mx_q   = 1'b0;
   reg  [2:0]  cnt_q  = 3'h0;
   integer     k;
   wire [3:0]  idx  = mx_q ? mx_a_q : demux_address_bus[3:0];
   wire [15:0] wd   = mx_q ? muxed_addr_data_bus_out : demux_data_bus_out;
   // released lines show the inverse of the last word
   wire [15:0] rd_w = read_n ? ~last_q : mem[idx];
   initial for (k = 0; k < 16; k = k + 1) mem[k] = 16'h0000;
   always @(posedge ref_clk) begin
      if (chip_select_n) mx_q <= 1'b0;
      else if (addr_latch) mx_q <= 1'b1;
      if (addr_latch) mx_a_q <= muxed_addr_data_bus_out[3:0];
      if (!read_n) last_q <= mem[idx];
      if (!write_lo_n) mem[idx][7:0] <= wd[7:0];
      if (!write_hi_n) mem[idx][15:8] <= wd[15:8];
   end
   always @(posedge lk_clk or posedge chip_select_n)
      if (chip_select_n) cnt_q <= 3'h0;
      else if (cnt_q != 3'h7) cnt_q <= cnt_q + 3'h1;
   // ready only inside a strobe, gone as soon as it ends
   assign ready_in = ((cnt_q >= rdy_dly) & ~(read_n & write_lo_n & write_hi_n)) ^ rdy_pol;
   assign demux_data_bus_in = demux_data_bus_oe ? demux_data_bus_out : rd_w;
   assign muxed_addr_data_bus_in = muxed_addr_data_bus_oe ? muxed_addr_data_bus_out : rd_w;
endmodule

// file: verification/external_bus_phase_sequencer_test.sv
// self-checking bench for the external bus phase sequencer
// assumes ebps_top, ebps_mem_model and the checker bind compiled before it
`timescale 1ns/1ps
`include "ebps_consts.vh"
module external_bus_phase_sequencer_test;
   reg         ref_clk = 1'b0;
   reg         lk_clk  = 1'b0;
   reg         reset   = 1'b1;
   reg  [3:0]  reg_addr = 4'h0;
   reg  [15:0] reg_wdata = 16'h0000;
   reg         reg_wr  = 1'b0;
   reg         reg_rd  = 1'b0;
   reg         rdy_pol = 1'b0;
   reg  [2:0]  rdy_dly = 3'h0;
   reg         rd_pend = 1'b0;
   reg  [31:0] seed    = 32'h0000_0008;
   reg  [15:0] mirror [0:15];
   reg  [15:0] exp_q [$];
   reg  [7:0]  win     = 8'h00;
   reg         win_ok  = 1'b0;
   reg  [15:0] cs_len  = 16'h0000;
   reg  [31:0] r;
   reg  [23:0] a;
   reg  [15:0] c, t0, t1, d;
   reg  [1:0]  be;
   integer     fail_count = 0;
   integer     n_tests = 0;
   integer     i;
   wire [15:0] reg_rdata, dd_in, dd_out, md_in, md_out;
   wire [23:0] addr_bus;
   wire        cs_n, ale, rd_n, wl_n, wh_n, clk_o, dd_oe, md_oe, rdy;
   always #2 ref_clk = ~ref_clk;
   initial begin
      #5;
      forever #16 lk_clk = ~lk_clk;
   end
   ebps_top i_ebps_top (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_reference_clock_out(clk_o),
      .external_clock_pin_output(), .chip_select_n(cs_n), .addr_latch(ale), .read_n(rd_n),
      .write_lo_n(wl_n), .write_hi_n(wh_n), .upper_byte_enable_n(), .demux_address_bus(addr_bus),
      .demux_data_bus_in(dd_in), .demux_data_bus_out(dd_out), .demux_data_bus_oe(dd_oe),
      .muxed_addr_data_bus_in(md_in), .muxed_addr_data_bus_out(md_out),
      .muxed_addr_data_bus_oe(md_oe), .ready_in(rdy));
   ebps_mem_model i_ebps_mem_model (.ref_clk(ref_clk), .lk_clk(lk_clk), .rdy_pol(rdy_pol),
      .rdy_dly(rdy_dly), .chip_select_n(cs_n), .addr_latch(ale), .read_n(rd_n), .write_lo_n(wl_n),
      .write_hi_n(wh_n), .demux_address_bus(addr_bus), .demux_data_bus_out(dd_out),
      .demux_data_bus_oe(dd_oe), .muxed_addr_data_bus_out(md_out), .muxed_addr_data_bus_oe(md_oe),
      .demux_data_bus_in(dd_in), .muxed_addr_data_bus_in(md_in), .ready_in(rdy));
   function logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task chk(input string nm, input [15:0] s, input [15:0] e);
      n_tests++;
      if (s !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task wr(input [3:0] ad, input [15:0] wd);
      @(posedge ref_clk);
      reg_wr <= 1'b1; reg_addr <= ad; reg_wdata <= wd;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task rd_chk(input [3:0] ad, input [15:0] e);
      @(posedge ref_clk);
      reg_rd <= 1'b1; reg_addr <= ad; exp_q.push_back(e);
      @(posedge ref_clk);
      reg_rd <= 1'b0;
   endtask
   always @(posedge ref_clk) begin
      if (rd_pend) chk("reg_rdata", reg_rdata, exp_q.pop_front());
      rd_pend <= reg_rd;
      cs_len <= cs_n ? 16'h0000 : cs_len + 16'h0001;
   end
   task wait_cs(input lvl);
      integer n;
      n = 0;
      while (cs_n !== lvl && n < 400) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 400) begin
         fail_count++;
         tally_and_finish;
      end
   endtask
   // one bus cycle; bw also tries a timing write while busy
   task run(input bw);
      integer e;
      e = 2 + t0[0] + t0[4:3] + t0[5] + t1[4:0] + t0[7:6] + ((win_ok && win == a[23:16]) ? 0 : t0[2:1]);
      wr(`EBPS_REG_ADDR_LO, a[15:0]);
      wr(`EBPS_REG_ADDR_HI, {8'h00, a[23:16]});
      wr(`EBPS_REG_WDATA, d);
      wr(`EBPS_REG_TIMING0, t0);
      wr(`EBPS_REG_TIMING1, t1);
      wr(`EBPS_REG_CTRL, c);
      wait_cs(1'b0);
      chk("addr_lo", addr_bus[15:0], a[15:0]);
      chk("addr_hi", {8'h00, addr_bus[23:16]}, {8'h00, a[23:16]});
      if (bw) wr(`EBPS_REG_TIMING1, ~t1);
      wait_cs(1'b1);
      if (!c[3]) chk("cs_len", cs_len, e[15:0]);
      else chk("cs_min", 16'(cs_len >= e), 16'h0001);
      win = a[23:16];
      win_ok = 1'b1;
      rd_chk(`EBPS_REG_STATUS, 16'h0002);
      if (bw) rd_chk(`EBPS_REG_TIMING1, t1);
      @(posedge ref_clk);
      #1;
      chk("clk_out", 16'(clk_o), 16'(c[8]));
   endtask
   initial begin
      for (i = 0; i < 16; i++) mirror[i] = 16'h0000;
      repeat (16) @(posedge ref_clk);
      reset <= 1'b0;
      rd_chk(`EBPS_REG_CTRL, `EBPS_CTRL_RESET);
      rd_chk(`EBPS_REG_TIMING0, `EBPS_T0_RESET);
      rd_chk(`EBPS_REG_TIMING1, `EBPS_T1_RESET);
      rd_chk(4'hc, 16'h0000);
      for (i = 0; i < 16; i++) begin
         r = xs();
         a = {7'h00, r[0], 12'h000, r[4:1]};
         be = (r[23:22] == 2'b00) ? 2'b11 : r[23:22];
         d = r[31:16] ^ r[15:0];
         t0 = {8'h00, r[12:5]};
         t1 = (i == 0) ? 16'h001f : {11'h000, r[17:13]};
         rdy_pol <= r[20];
         rdy_dly <= r[27:25];
         c = {7'h00, r[24], be, r[21:18], 2'b11};
         run(i == 0);
         if (be[0]) mirror[a[3:0]][7:0] = d[7:0];
         if (be[1]) mirror[a[3:0]][15:8] = d[15:8];
         c = {7'h00, r[24], 2'b11, r[21:18], 2'b01};
         run(1'b0);
         rd_chk(`EBPS_REG_RDATA, mirror[a[3:0]]);
      end
      // let the last queued read reach its compare
      repeat (2) @(posedge ref_clk);
      tally_and_finish;
   end
endmodule
